// file: hdl/rwd_watchdog.sv
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Function
// - one-command refresh is opcode plus inverted code; each refresh returns fresh code.
// - two-command refresh: upper inverted nibble first, then lower nibble, others zero.
// - second partial refresh returns a fresh random code for the next pair.
// - four-command refresh carries two inverted bits each, pairs 7:6 down to 1:0.
// - fourth partial refresh returns a fresh random code for next sequence.
// - interrupt register must be read within two watchdog periods of an interrupt; code fails at the second period end, and a refresh restarts the period.
// - interrupt-response supervision runs only when configuration bit 7 is set.
// - code read command returns random code in second response byte.
// - open window starts at half period and lasts to period end.
// - refresh before half period or missing refresh by period end forces reset.
module rwd_watchdog
   import rwd_pkg::*;
#(
   parameter int TICK_DIV = rwd_pkg::TICK_CYCLES
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // device events
   input  wire logic        int_event,
   input  wire logic        int_reg_read,
   // outputs
   output logic             irq,
   output logic             wd_reset_req
);
   import rwd_pkg::*;

   rwd_tmr_if   tif ();
   logic [7:0]  cfg;
   logic [15:0] period_ms;
   logic [2:0]  stat;
   logic [2:0]  mask;
   logic [7:0]  random_challenge_code;
   logic [15:0] miso;
   logic [7:0]  lfsr_code;
   logic [1:0]  part_idx;
   logic        part_bad;
   logic        int_pending;
   logic [1:0]  int_periods;
   rwd_mode_e   mode;
   logic        acc, wr, setup, mapped;
   logic        cmd_wr, refresh, rnd_read, part_ok, last, complete;
   logic        early, timeout, bad_code, int_fail, fail;
   logic [7:0]  expected;
   logic [2:0]  next_stat;

   // ****************************************
   // submodules
   // ****************************************
   rwd_timer #(.TICK_DIV(TICK_DIV)) u_timer (.clk(clk), .sys_rst(sys_rst), .tif(tif.tmr));
   rwd_lfsr u_lfsr (.clk(clk), .sys_rst(sys_rst), .code(lfsr_code));

   assign tif.period_ms = period_ms;
   assign tif.restart   = complete || fail;

   // ****************************************
   // apb decode
   // ****************************************
   assign setup  = psel && !penable;
   assign acc    = psel && penable && pready;
   assign wr     = acc && pwrite;
   assign mapped = (paddr == ADDR_CMD) || (paddr == ADDR_CFG) || (paddr == ADDR_PERIOD) ||
                   (paddr == ADDR_STAT) || (paddr == ADDR_MASK) || (paddr == ADDR_RND);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         unique case (paddr)
            ADDR_CMD:    prdata <= {16'h0000, miso};
            ADDR_CFG:    prdata <= {24'h000000, cfg};
            ADDR_PERIOD: prdata <= {16'h0000, period_ms};
            ADDR_STAT:   prdata <= {28'h0000000, tif.open_win, stat};
            ADDR_MASK:   prdata <= {29'h00000000, mask};
            ADDR_RND:    prdata <= {24'h000000, random_challenge_code};
            default:     prdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg       <= CFG_RST;
         period_ms <= PERIOD_RST;
         mask      <= MASK_RST;
      end else if (wr) begin
         if (paddr == ADDR_CFG) cfg <= pwdata[7:0];
         if (paddr == ADDR_PERIOD) period_ms <= pwdata[15:0];
         if (paddr == ADDR_MASK) mask <= pwdata[2:0];
      end
   end

   // ****************************************
   // refresh command check
   // ****************************************
   assign mode      = rwd_mode_e'(cfg[CFG_MODE_LSB +: 2]);
   assign cmd_wr    = wr && (paddr == ADDR_CMD);
   assign refresh   = cmd_wr && (pwdata[15:8] == OP_REFRESH);
   assign rnd_read  = cmd_wr && (pwdata[15:0] == OP_RND_READ);
   assign expected  = ~random_challenge_code & rwd_part_mask(mode, part_idx);
   assign part_ok   = (pwdata[7:0] == expected);
   assign last      = (part_idx == rwd_last_idx(mode));
   assign complete  = refresh && last;
   assign early     = complete && cfg[CFG_WIN_BIT] && !tif.open_win;
   assign bad_code  = complete && (part_bad || !part_ok);
   assign timeout   = tif.period_end && !complete;
   assign fail      = early || bad_code || timeout || int_fail;

   always_ff @(posedge clk) begin
      if (sys_rst || complete || fail) begin
         part_idx <= 2'h0;
         part_bad <= 1'b0;
      end else if (refresh) begin
         part_idx <= part_idx + 2'h1;
         part_bad <= part_bad || !part_ok;
      end
   end

   // fresh code on every completed refresh outside RWD_SIMPLE mode and after a failure
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         random_challenge_code <= 8'h00;
      end else if ((complete && mode != RWD_SIMPLE) || fail) begin
         random_challenge_code <= lfsr_code;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         miso <= 16'h0000;
      end else if (complete && mode != RWD_SIMPLE) begin
         miso <= {8'h00, lfsr_code};
      end else if (rnd_read) begin
         miso <= {8'h00, random_challenge_code};
      end else if (cmd_wr) begin
         miso <= 16'h0000;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wd_reset_req <= 1'b0;
      end else begin
         wd_reset_req <= fail;
      end
   end

   // ****************************************
   // interrupt response supervision
   // ****************************************
   assign int_fail = int_pending && tif.period_end && (int_periods == INT_PERIODS - 2'h1);

   always_ff @(posedge clk) begin
      if (sys_rst || !cfg[CFG_INTCHK_BIT]) begin
         int_pending <= 1'b0;
         int_periods <= 2'h0;
      end else if (int_event) begin
         int_pending <= 1'b1;
         int_periods <= 2'h0;
      end else if (int_reg_read || int_fail) begin
         int_pending <= 1'b0;
      end else if (int_pending && tif.period_end) begin
         int_periods <= int_periods + 2'h1;
      end
   end

   // ****************************************
   // status and interrupt
   // ****************************************
   always_comb begin
      next_stat = stat;
      if (wr && paddr == ADDR_STAT) next_stat = stat & ~pwdata[2:0];
      if (complete && !fail) next_stat[ST_REFRESH] = 1'b1;
      if (fail) next_stat[ST_WD_FAIL] = 1'b1;
      if (int_fail) next_stat[ST_INT_FAIL] = 1'b1;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stat <= STAT_RST;
         irq  <= 1'b0;
      end else begin
         stat <= next_stat;
         irq  <= |(next_stat & ((wr && paddr == ADDR_MASK) ? pwdata[2:0] : mask));
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   AST_FRESH_CODE: assert property (@(posedge clk) disable iff (sys_rst)
      (complete && mode == RWD_ADV1) |=> (miso[7:0] == random_challenge_code) && (miso[15:8] == 8'h00))
      else $error("single refresh did not return new code");
   AST_WIN_EARLY: assert property (@(posedge clk) disable iff (sys_rst)
      (complete && cfg[CFG_WIN_BIT] && !tif.open_win) |=> wd_reset_req)
      else $error("early refresh did not reset");
   AST_NIBBLE: assert property (@(posedge clk) disable iff (sys_rst)
      (refresh && !fail && mode == RWD_ADV2 && part_idx == 2'h0 && pwdata[3:0] != 4'h0) |=> part_bad)
      else $error("low nibble of first partial not checked");
   AST_PAIR_DONE: assert property (@(posedge clk) disable iff (sys_rst)
      (refresh && mode == RWD_ADV2 && part_idx == 2'h1) |=> (part_idx == 2'h0) && (miso[7:0] == random_challenge_code))
      else $error("second partial did not complete pair");
   AST_QUAD_STEP: assert property (@(posedge clk) disable iff (sys_rst)
      (refresh && !fail && mode == RWD_ADV4 && part_idx != 2'h3) |=> part_idx == $past(part_idx) + 2'h1)
      else $error("partial index did not advance");
   AST_QUAD_CODE: assert property (@(posedge clk) disable iff (sys_rst)
      (complete && mode == RWD_ADV4) |=> (miso[7:0] == random_challenge_code) && (part_idx == 2'h0))
      else $error("fourth partial did not return new code");
   AST_INT_LATE: assert property (@(posedge clk) disable iff (sys_rst)
      int_fail |=> wd_reset_req && stat[ST_INT_FAIL] && !int_pending)
      else $error("late interrupt read not reported");
   AST_INT_OFF: assert property (@(posedge clk) disable iff (sys_rst)
      !cfg[CFG_INTCHK_BIT] |=> !int_pending)
      else $error("supervision active while disabled");
   AST_RND_READ: assert property (@(posedge clk) disable iff (sys_rst)
      (rnd_read && !fail) |=> miso == {8'h00, $past(random_challenge_code)})
      else $error("code read returned wrong byte");
   AST_TIMEOUT: assert property (@(posedge clk) disable iff (sys_rst)
      timeout |=> wd_reset_req ##1 !wd_reset_req)
      else $error("missing refresh did not reset");
   AST_BAD_CODE: assert property (@(posedge clk) disable iff (sys_rst)
      (complete && !part_ok) |=> wd_reset_req && stat[ST_WD_FAIL])
      else $error("wrong code not treated as failure");

   // ****************************************
   // bus assertions
   // ****************************************
   AST_PREADY_SETUP: assert property (@(posedge clk) disable iff (sys_rst)
      (psel && !penable) |=> pready)
      else $error("setup phase not answered");
   AST_PREADY_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
      pready |=> !pready)
      else $error("ready held past the access cycle");
   AST_SLVERR_QUAL: assert property (@(posedge clk) disable iff (sys_rst)
      pslverr |-> pready)
      else $error("error response without ready");
   AST_UNMAPPED_WR: assert property (@(posedge clk) disable iff (sys_rst)
      (wr && !mapped) |=> $stable(cfg) && $stable(period_ms) && $stable(mask))
      else $error("write to unmapped address changed a register");
   AST_PERIOD_WR: assert property (@(posedge clk) disable iff (sys_rst)
      (wr && paddr == ADDR_PERIOD) |=> period_ms == $past(pwdata[15:0]))
      else $error("period write lost");

   // ****************************************
   // refresh assertions
   // ****************************************
   AST_CODE_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
      (!complete && !fail) |=> $stable(random_challenge_code))
      else $error("code changed between refreshes");
   AST_PART_RESTART: assert property (@(posedge clk) disable iff (sys_rst)
      fail |=> (part_idx == 2'h0) && !part_bad)
      else $error("failure left a partial sequence open");
   AST_WIN_OK: assert property (@(posedge clk) disable iff (sys_rst)
      (complete && tif.open_win && part_ok && !part_bad && !int_fail) |=> !wd_reset_req)
      else $error("refresh in open window rejected");
   AST_REFRESH_OK: assert property (@(posedge clk) disable iff (sys_rst)
      (complete && !fail) |=> stat[ST_REFRESH])
      else $error("good refresh not reported");
   AST_MISO_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
      (cmd_wr && !refresh && !rnd_read) |=> miso == 16'h0000)
      else $error("other command left response word");

   // ****************************************
   // interrupt assertions
   // ****************************************
   AST_INT_ARM: assert property (@(posedge clk) disable iff (sys_rst)
      (cfg[CFG_INTCHK_BIT] && int_event) |=> int_pending && (int_periods == 2'h0))
      else $error("interrupt not armed");
   AST_INT_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
      (int_reg_read && !int_event) |=> !int_pending)
      else $error("register read did not end supervision");
   AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (sys_rst)
      irq == |(stat & mask))
      else $error("interrupt output does not follow status");
endmodule : rwd_watchdog
`default_nettype wire

// file: hdl/rwd_pkg.sv
`default_nettype none
package rwd_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0]  ADDR_CMD    = 8'h00;
   localparam logic [7:0]  ADDR_CFG    = 8'h04;
   localparam logic [7:0]  ADDR_PERIOD = 8'h08;
   localparam logic [7:0]  ADDR_STAT   = 8'h0c;
   localparam logic [7:0]  ADDR_MASK   = 8'h10;
   localparam logic [7:0]  ADDR_RND    = 8'h14;
   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int          CFG_WIN_BIT    = 1;
   localparam int          CFG_MODE_LSB   = 2;
   localparam int          CFG_INTCHK_BIT = 7;
   localparam logic [7:0]  CFG_RST        = 8'h02;
   localparam logic [15:0] PERIOD_RST     = 16'h0100;
   localparam int          ST_REFRESH     = 0;
   localparam int          ST_WD_FAIL     = 1;
   localparam int          ST_INT_FAIL    = 2;
   localparam logic [2:0]  STAT_RST       = 3'h0;
   localparam logic [2:0]  MASK_RST       = 3'h0;
   localparam logic [15:0] LFSR_SEED      = 16'hace1;
   // ****************************************
   // commands
   // ****************************************
   localparam logic [7:0]  OP_REFRESH  = 8'h5a;
   localparam logic [15:0] OP_RND_READ = 16'h1b00;
   // ****************************************
   // timing
   // ****************************************
   localparam int          CLK_PERIOD_NS = 100;
   localparam int          MS_TIME_NS    = 1000000;
   localparam int          TICK_CYCLES   = MS_TIME_NS / CLK_PERIOD_NS;
   localparam logic [1:0]  INT_PERIODS   = 2'h2;

   typedef enum logic [1:0] {RWD_SIMPLE, RWD_ADV1, RWD_ADV2, RWD_ADV4} rwd_mode_e;

   // bits of the inverted code expected in partial command idx
   function automatic logic [7:0] rwd_part_mask(input rwd_mode_e mode, input logic [1:0] idx);
      logic [7:0] m;
      m = 8'h00;
      unique case (mode)
         RWD_SIMPLE: m = 8'h00;
         RWD_ADV1:   m = 8'hff;
         RWD_ADV2:   m = (idx == 2'h0) ? 8'hf0 : 8'h0f;
         RWD_ADV4:   m = 8'hc0 >> {idx, 1'b0};
      endcase
      return m;
   endfunction : rwd_part_mask

   function automatic logic [1:0] rwd_last_idx(input rwd_mode_e mode);
      return (mode == RWD_ADV4) ? 2'h3 : (mode == RWD_ADV2) ? 2'h1 : 2'h0;
   endfunction : rwd_last_idx
endpackage : rwd_pkg
`default_nettype wire

// file: hdl/rwd_tmr_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rwd_tmr_if;
   logic        restart;
   logic [15:0] period_ms;
   logic        open_win;
   logic        period_end;
   modport ctl (output restart, output period_ms, input open_win, input period_end);
   modport tmr (input restart, input period_ms, output open_win, output period_end);
endinterface : rwd_tmr_if
`default_nettype wire

// file: hdl/rwd_lfsr.sv
`timescale 1ns/1ns
`default_nettype none
module rwd_lfsr
   import rwd_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // free-running code
   output logic      [7:0] code
);
   logic [15:0] state;

   // ****************************************
   // free-running generator, sampled on demand
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= LFSR_SEED;
      end else begin
         state <= {state[14:0], state[15] ^ state[13] ^ state[12] ^ state[10]};
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         code <= 8'h00;
      end else begin
         code <= state[7:0];
      end
   end
endmodule : rwd_lfsr
`default_nettype wire

// file: hdl/rwd_timer.sv
`timescale 1ns/1ns
`default_nettype none
module rwd_timer
   import rwd_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
)(
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // control side
   rwd_tmr_if.tmr    tif
);
   logic [15:0] div_cnt;
   logic        ms_tick;
   logic [15:0] ms_cnt;
   logic [15:0] period;

   assign period = (tif.period_ms == 16'h0000) ? 16'h0001 : tif.period_ms;

   // ****************************************
   // millisecond enable
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst || tif.restart) begin
         div_cnt <= 16'h0000;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= (div_cnt == 16'(TICK_DIV - 1));
         div_cnt <= (div_cnt == 16'(TICK_DIV - 1)) ? 16'h0000 : div_cnt + 16'h0001;
      end
   end

   // ****************************************
   // period counter and open window
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst || tif.restart) begin
         ms_cnt         <= 16'h0000;
         tif.period_end <= 1'b0;
      end else begin
         tif.period_end <= ms_tick && (ms_cnt == period - 16'h0001);
         if (ms_tick) begin
            ms_cnt <= (ms_cnt == period - 16'h0001) ? 16'h0000 : ms_cnt + 16'h0001;
         end
      end
   end

   assign tif.open_win = (ms_cnt >= (period >> 1));

   AST_WIN_HALF: assert property (@(posedge clk) disable iff (sys_rst)
      (ms_tick && !tif.restart && ms_cnt == (period >> 1) - 16'h0001) |=> tif.open_win)
      else $error("window not open at half period");
endmodule : rwd_timer
`default_nettype wire

// file: tb/rwd_host.sv
`timescale 1ns/1ns
`default_nettype none
module rwd_host
   import rwd_pkg::*;
(
   // clock
   input  wire logic        clk,
   // apb master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [7:0]  paddr,
   output logic      [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready
);
   logic hang;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      hang = 1'b0;
   end
   // ********
   // bus cycle
   // ********
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      int n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) hang = 1'b1;
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines show no stale value
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge clk);
   endtask : xfer

   task automatic get_code(output logic [7:0] c);
      logic [31:0] r;
      xfer(1'b1, ADDR_CMD, {16'h0, OP_RND_READ}, r);
      xfer(1'b0, ADDR_CMD, 32'h0, r);
      c = r[7:0];
   endtask : get_code

   task automatic wait_win();
      logic [31:0] r;
      int          n = 0;
      do begin
         xfer(1'b0, ADDR_STAT, 32'h0, r);
         n++;
      end while (r[3] !== 1'b1 && n < 2000);
      if (r[3] !== 1'b1) hang = 1'b1;
   endtask : wait_win

   // inverted code in partials, upper bits first; bad flips bits, early skips the window
   task automatic refresh(input rwd_mode_e md, input logic [7:0] c, input logic [7:0] bad,
                          input logic early);
      logic [31:0] r;
      logic [7:0]  m;
      int          last;
      last = (md == RWD_ADV4) ? 3 : (md == RWD_ADV2) ? 1 : 0;
      for (int i = 0; i <= last; i++) begin
         m = (md == RWD_ADV4) ? (8'hc0 >> (2 * i)) :
             (md == RWD_ADV2) ? ((i == 0) ? 8'hf0 : 8'h0f) :
             (md == RWD_ADV1) ? 8'hff : 8'h00;
         if (i == last && !early) wait_win();
         xfer(1'b1, ADDR_CMD, {16'h0, OP_REFRESH, (~c & m) ^ bad}, r);
      end
   endtask : refresh
endmodule : rwd_host
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   import rwd_pkg::*;
   typedef struct {
      logic [32:0] v;
      logic [32:0] m;
   } rwd_note_s;
   logic        clk;
   logic        sys_rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        int_event;
   logic        int_reg_read;
   logic        irq;
   logic        wd_reset_req;
   logic [31:0] r;
   logic [31:0] xs;
   logic [7:0]  c;
   int          num_errors;
   int          checks_done;
   int          fails;
   int          base;
   rwd_note_s   notes[$];

   rwd_watchdog #(.TICK_DIV(10)) u_rwd_watchdog (
      .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .int_event(int_event),
      .int_reg_read(int_reg_read), .irq(irq), .wd_reset_req(wd_reset_req));
   rwd_host u_rwd_host (
      .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ********
   // helpers
   // ********
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction : xorshift

   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic rd_exp(input logic [7:0] a, input logic [32:0] v, input logic [32:0] m);
      notes.push_back('{v, m});
      u_rwd_host.xfer(1'b0, a, 32'h0, r);
   endtask : rd_exp

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_rwd_host.xfer(1'b1, a, d, r);
   endtask : wr

   task automatic pulse_int(input logic rd);
      int_reg_read <= rd;
      int_event <= !rd;
      @(posedge clk);
      int_reg_read <= 1'b0;
      int_event <= 1'b0;
   endtask : pulse_int

   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   // read results against the oldest note, failure pulses counted
   always @(posedge clk) begin
      if (wd_reset_req === 1'b1) fails++;
      if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
         chk({pslverr, prdata} & notes[0].m, notes[0].v & notes[0].m);
         void'(notes.pop_front());
      end
      if (u_rwd_host.hang === 1'b1) begin
         num_errors++;
         end_of_test();
      end
   end

   initial begin
      repeat (90000) @(posedge clk);
      num_errors++;
      end_of_test();
   end
   // ********
   // main sequence
   // ********
   initial begin
      sys_rst = 1'b1;
      int_event = 1'b0;
      int_reg_read = 1'b0;
      num_errors = 0;
      checks_done = 0;
      fails = 0;
      xs = 32'd73178;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd_exp(ADDR_CFG, {25'h0, CFG_RST}, '1);
      rd_exp(ADDR_PERIOD, {17'h0, PERIOD_RST}, '1);
      rd_exp(ADDR_STAT, {30'h0, STAT_RST}, '1);
      rd_exp(ADDR_MASK, {30'h0, MASK_RST}, '1);
      rd_exp(8'h18, {1'b1, 32'h0}, '1);
      xs = xorshift(xs);
      wr(ADDR_MASK, xs);
      rd_exp(ADDR_MASK, {30'h0, xs[2:0]}, '1);
      wr(ADDR_MASK, 32'h7);
      wr(ADDR_PERIOD, 32'h8);
      $display("test regs done");
      for (int md = 0; md < 4; md++) begin
         wr(ADDR_CFG, 32'h2 | (md << CFG_MODE_LSB));
         base = fails;
         u_rwd_host.get_code(c);
         u_rwd_host.refresh(rwd_mode_e'(md), c, 8'h00, 1'b0);
         rd_exp(ADDR_STAT, 33'h1, 33'h3);
         chk(33'(fails - base), 33'h0);
         u_rwd_host.xfer(1'b0, ADDR_RND, 32'h0, r);
         c = r[7:0];
         rd_exp(ADDR_CMD, {25'h0, (md == 0) ? 8'h00 : c}, '1);
         chk({32'h0, irq}, 33'h1);
         wr(ADDR_STAT, 32'h7);
         repeat (2) @(posedge clk);
         chk({32'h0, irq}, 33'h0);
      end
      wr(ADDR_CMD, 32'h1234);
      rd_exp(ADDR_CMD, 33'h0, '1);
      $display("test refresh modes done");
      wr(ADDR_CFG, 32'h6);
      base = fails;
      u_rwd_host.get_code(c);
      xs = xorshift(xs);
      u_rwd_host.refresh(RWD_ADV1, c, xs[7:0] | 8'h01, 1'b0);
      rd_exp(ADDR_STAT, 33'h2, 33'h3);
      wr(ADDR_STAT, 32'h7);
      wr(ADDR_CFG, 32'ha);
      u_rwd_host.get_code(c);
      u_rwd_host.refresh(RWD_ADV2, c, {4'h0, xs[11:8] | 4'h1}, 1'b0);
      rd_exp(ADDR_STAT, 33'h2, 33'h3);
      wr(ADDR_STAT, 32'h7);
      wr(ADDR_CFG, 32'h6);
      u_rwd_host.get_code(c);
      u_rwd_host.refresh(RWD_ADV1, c, 8'h00, 1'b1);
      rd_exp(ADDR_STAT, 33'h2, 33'h3);
      chk(33'(fails - base), 33'h3);
      repeat (85) @(posedge clk);
      chk(33'(fails - base), 33'h4);
      $display("test failures done");
      wr(ADDR_CFG, 32'h86);
      wr(ADDR_STAT, 32'h7);
      pulse_int(1'b0);
      repeat (10) @(posedge clk);
      pulse_int(1'b1);
      repeat (250) @(posedge clk);
      rd_exp(ADDR_STAT, 33'h0, 33'h4);
      pulse_int(1'b0);
      repeat (250) @(posedge clk);
      rd_exp(ADDR_STAT, 33'h4, 33'h4);
      wr(ADDR_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk({32'h0, irq}, 33'h0);
      wr(ADDR_MASK, 32'h7);
      wr(ADDR_CFG, 32'h06);
      wr(ADDR_STAT, 32'h7);
      pulse_int(1'b0);
      repeat (250) @(posedge clk);
      rd_exp(ADDR_STAT, 33'h0, 33'h4);
      $display("test int check done");
      end_of_test();
   end
endmodule : tb
`default_nettype wire
